// [design/pcd_core.sv]
// Purpose: Multi-cycle 8051-style core: decode, timing, operands, debug halt
// Assumes: code_bytes holds the three bytes at code_addr in the same cycle
// Notes:   Unexecuted opcodes advance by their length and timing only
module pcd_core #(
  parameter int NUM_BP = pcd_pkg::NUM_BP
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // Program memory
  output logic [15:0]                 code_addr,
  input  wire logic [23:0]            code_bytes,
  // Peripheral register writes
  output pcd_pkg::pcd_sfr_wr_t        sfr_wr,
  // Debug port
  input  wire pcd_pkg::pcd_dbg_t      dbg_req,
  input  wire logic [NUM_BP-1:0]      dbg_bp_en,
  input  wire logic [NUM_BP-1:0][15:0] dbg_bp_addr,
  output logic                        dbg_halted,
  output logic [7:0]                  dbg_rdata
);
  logic [7:0]            ram_mem [0:255];
  pcd_pkg::pcd_state_t   state_reg, state_next;
  pcd_pkg::pcd_dec_t     dec;
  pcd_pkg::pcd_sfr_wr_t  sfr_reg;
  logic [15:0]           pc_reg, pc_next, pc_seq;
  logic [15:0]           rel_tgt, page_tgt, full_tgt, rel_ext;
  logic [3:0]            cnt_reg, need;
  logic [7:0]            stk_reg, stk_next, work_reg, work_next;
  logic [7:0]            second_reg, second_next, stat_reg, stat_next;
  logic [7:0]            ptrl_reg, ptrl_next, ptrh_reg, ptrh_next;
  logic [7:0]            op, b1, b2, stat_val, bank_addr, ptr_addr, ind_addr;
  logic [7:0]            bit_byte, bit_val, push_val, rd_val, wr_addr, wr_data;
  logic [8:0]            sum9;
  logic [4:0]            nib5, seq_page;
  logic                  step_reg, pend_reg, halted_reg;
  logic                  exec, commit, taken, is_call, call_lo_we;
  logic                  wr_en, wr_ind, ram_we, ext_we, bp_hit;
  logic [7:0]            rdata_reg;

  assign op       = code_bytes[7:0];
  assign b1       = code_bytes[15:8];
  assign b2       = code_bytes[23:16];
  assign pc_seq   = pc_reg + {14'h0000, dec.len};
  assign seq_page = pc_seq[15:11];
  assign rel_ext  = {{8{b1[7]}}, b1};
  assign ind_addr = ram_mem[ptr_addr];
  assign stat_val = {stat_reg[7:1], ^work_reg};
  assign sum9     = {1'b0, work_reg} + {1'b0, b1};
  assign nib5     = {1'b0, work_reg[3:0]} + {1'b0, b1[3:0]};

  pcd_decode u_decode (
    .opcode (op),
    .dec    (dec)
  );

  pcd_operand u_operand (
    .op        (op),
    .b1        (b1),
    .b2        (b2),
    .bank      (stat_reg[pcd_pkg::F_BNKH:pcd_pkg::F_BNKL]),
    .pc_seq    (pc_seq),
    .bank_addr (bank_addr),
    .ptr_addr  (ptr_addr),
    .bit_byte  (bit_byte),
    .rel_tgt   (rel_tgt),
    .page_tgt  (page_tgt),
    .full_tgt  (full_tgt)
  );

  function automatic logic [7:0] sfr_rd(input logic [7:0] a);
    case (a)
      pcd_pkg::A_STK:    return stk_reg;
      pcd_pkg::A_PTRL:   return ptrl_reg;
      pcd_pkg::A_PTRH:   return ptrh_reg;
      pcd_pkg::A_STAT:   return stat_val;
      pcd_pkg::A_WORK:   return work_reg;
      pcd_pkg::A_SECOND: return second_reg;
      default:           return pcd_pkg::REG_RST;
    endcase
  endfunction : sfr_rd

  function automatic logic [7:0] dir_rd(input logic [7:0] a);
    return (a >= pcd_pkg::SFR_BASE) ? sfr_rd(a) : ram_mem[a];
  endfunction : dir_rd

  function automatic logic is_core(input logic [7:0] a);
    return a inside {pcd_pkg::A_STK, pcd_pkg::A_PTRL, pcd_pkg::A_PTRH,
                     pcd_pkg::A_STAT, pcd_pkg::A_WORK, pcd_pkg::A_SECOND};
  endfunction : is_core

  assign taken = (dec.cls == pcd_pkg::C_JC  &&  stat_reg[pcd_pkg::F_CY]) ||
                 (dec.cls == pcd_pkg::C_JNC && !stat_reg[pcd_pkg::F_CY]) ||
                 (dec.cls == pcd_pkg::C_JZ  && work_reg == 8'h00) ||
                 (dec.cls == pcd_pkg::C_JNZ && work_reg != 8'h00);
  assign need       = dec.cyc + {3'b000, taken};
  assign exec       = state_reg == pcd_pkg::ST_EXEC;
  assign commit     = exec && cnt_reg == need;
  assign is_call    = dec.cls inside {pcd_pkg::C_ACALL, pcd_pkg::C_LCALL};
  assign call_lo_we = exec && is_call && cnt_reg == 4'h1;
  assign ram_we     = wr_en && (wr_ind || wr_addr < pcd_pkg::SFR_BASE);
  assign ext_we     = wr_en && !wr_ind && wr_addr >= pcd_pkg::SFR_BASE && !is_core(wr_addr);

  // Single write bus: debug when halted, else the committing instruction
  always_comb begin
    push_val = dir_rd(b1);
    bit_val  = dir_rd(bit_byte);
    rd_val   = dbg_req.sfr ? sfr_rd(dbg_req.addr) : ram_mem[dbg_req.addr];
    wr_en    = 1'b0;
    wr_ind   = 1'b0;
    wr_addr  = 8'h00;
    wr_data  = 8'h00;
    if (halted_reg) begin
      wr_en   = dbg_req.we;
      wr_ind  = !dbg_req.sfr;
      wr_addr = dbg_req.addr;
      wr_data = dbg_req.wdata;
    end else if (commit) begin
      wr_en = 1'b1;
      case (dec.cls)
        pcd_pkg::C_ST_DIR:  {wr_addr, wr_data} = {b1, work_reg};
        pcd_pkg::C_MV_DIMM: {wr_addr, wr_data} = {b1, b2};
        pcd_pkg::C_POP:     {wr_addr, wr_data} = {b1, ram_mem[stk_reg]};
        pcd_pkg::C_ST_BNK:  {wr_ind, wr_addr, wr_data} = {1'b1, bank_addr, work_reg};
        pcd_pkg::C_ST_IND:  {wr_ind, wr_addr, wr_data} = {1'b1, ind_addr, work_reg};
        pcd_pkg::C_PUSH: {wr_ind, wr_addr, wr_data} = {1'b1, stk_reg + 8'h01, push_val};
        pcd_pkg::C_ACALL, pcd_pkg::C_LCALL:
          {wr_ind, wr_addr, wr_data} = {1'b1, stk_reg + 8'h02, pc_seq[15:8]};
        pcd_pkg::C_CLR_BIT: {wr_addr, wr_data} = {bit_byte, bit_val & ~(8'h01 << b1[2:0])};
        pcd_pkg::C_SET_BIT: {wr_addr, wr_data} = {bit_byte, bit_val | (8'h01 << b1[2:0])};
        default:            wr_en = 1'b0;
      endcase
    end
  end

  // Register next values; a direct write to a register wins
  always_comb begin
    stk_next    = stk_reg;
    work_next   = work_reg;
    stat_next   = stat_reg;
    ptrl_next   = ptrl_reg;
    ptrh_next   = ptrh_reg;
    second_next = second_reg;
    pc_next     = pc_seq;
    if (commit) begin
      case (dec.cls)
        pcd_pkg::C_PUSH:   stk_next = stk_reg + 8'h01;
        pcd_pkg::C_POP:    stk_next = stk_reg - 8'h01;
        pcd_pkg::C_LD_IMM: work_next = b1;
        pcd_pkg::C_LD_DIR: work_next = dir_rd(b1);
        pcd_pkg::C_LD_BNK: work_next = ram_mem[bank_addr];
        pcd_pkg::C_LD_IND: work_next = ram_mem[ind_addr];
        pcd_pkg::C_INC_W:  work_next = work_reg + 8'h01;
        pcd_pkg::C_LD_PTR: {ptrh_next, ptrl_next} = {b1, b2};
        pcd_pkg::C_ADD_IMM: begin
          work_next            = sum9[7:0];
          stat_next[pcd_pkg::F_CY] = sum9[8];
          stat_next[pcd_pkg::F_AC] = nib5[4];
          stat_next[pcd_pkg::F_OV] = (work_reg[7] == b1[7]) && (sum9[7] != work_reg[7]);
        end
        default: stk_next = stk_reg;
      endcase
      case (dec.cls)
        pcd_pkg::C_AJMP: pc_next = page_tgt;
        pcd_pkg::C_ACALL: begin
          pc_next  = page_tgt;
          stk_next = stk_reg + 8'h02;
        end
        pcd_pkg::C_LJMP: pc_next = full_tgt;
        pcd_pkg::C_LCALL: begin
          pc_next  = full_tgt;
          stk_next = stk_reg + 8'h02;
        end
        pcd_pkg::C_SJMP: pc_next = rel_tgt;
        pcd_pkg::C_RET: begin
          pc_next  = {ram_mem[stk_reg], ram_mem[stk_reg - 8'h01]};
          stk_next = stk_reg - 8'h02;
        end
        default: pc_next = taken ? rel_tgt : pc_seq;
      endcase
    end
    if (wr_en && !wr_ind) begin
      case (wr_addr)
        pcd_pkg::A_STK:    stk_next = wr_data;
        pcd_pkg::A_PTRL:   ptrl_next = wr_data;
        pcd_pkg::A_PTRH:   ptrh_next = wr_data;
        pcd_pkg::A_STAT:   stat_next = wr_data;
        pcd_pkg::A_WORK:   work_next = wr_data;
        pcd_pkg::A_SECOND: second_next = wr_data;
        default:           stk_next = stk_next;
      endcase
    end
  end

  always_comb begin
    bp_hit = 1'b0;
    for (int i = 0; i < NUM_BP; i++) begin
      bp_hit = bp_hit | (dbg_bp_en[i] && dbg_bp_addr[i] == pc_next);
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pcd_pkg::ST_EXEC:
        if (commit && (bp_hit || step_reg || pend_reg || dbg_req.halt)) begin
          state_next = pcd_pkg::ST_HALT;
        end
      pcd_pkg::ST_HALT:
        if (dbg_req.run || dbg_req.step) begin
          state_next = pcd_pkg::ST_EXEC;
        end
      default: state_next = pcd_pkg::ST_HALT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (ram_we) begin
      ram_mem[wr_addr] <= wr_data;
    end else if (call_lo_we) begin
      ram_mem[stk_reg + 8'h01] <= pc_seq[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg  <= pcd_pkg::ST_EXEC;
      pc_reg     <= 16'h0000;
      cnt_reg    <= 4'h1;
      stk_reg    <= pcd_pkg::STK_RST;
      work_reg   <= pcd_pkg::REG_RST;
      stat_reg   <= pcd_pkg::REG_RST;
      ptrl_reg   <= pcd_pkg::REG_RST;
      ptrh_reg   <= pcd_pkg::REG_RST;
      second_reg <= pcd_pkg::REG_RST;
      step_reg   <= 1'b0;
      pend_reg   <= 1'b0;
      halted_reg <= 1'b0;
      rdata_reg  <= 8'h00;
      sfr_reg    <= '0;
    end else begin
      state_reg  <= state_next;
      pc_reg     <= commit ? pc_next : pc_reg;
      cnt_reg    <= (exec && !commit) ? cnt_reg + 4'h1 : 4'h1;
      stk_reg    <= stk_next;
      work_reg   <= work_next;
      stat_reg   <= stat_next;
      ptrl_reg   <= ptrl_next;
      ptrh_reg   <= ptrh_next;
      second_reg <= second_next;
      step_reg   <= halted_reg ? dbg_req.step : step_reg;
      pend_reg   <= (state_next == pcd_pkg::ST_HALT) ? 1'b0 : (pend_reg | dbg_req.halt);
      halted_reg <= state_next == pcd_pkg::ST_HALT;
      rdata_reg  <= rd_val;
      sfr_reg    <= '{we: ext_we, addr: wr_addr, data: wr_data};
    end
  end

  assign code_addr    = pc_reg;
  assign sfr_wr       = sfr_reg;
  assign dbg_halted   = halted_reg;
  assign dbg_rdata    = rdata_reg;

  property p_cyc_max;
    @(posedge sys_clk) disable iff (!resetn)
    exec |-> (cnt_reg <= pcd_pkg::MAX_CYC) && (need <= pcd_pkg::MAX_CYC);
  endproperty
  a_cyc_max: assert property (p_cyc_max)
    else $error("instruction runs past eight clocks");

  property p_len_time;
    @(posedge sys_clk) disable iff (!resetn)
    commit && dec.cls inside {pcd_pkg::C_NOP, pcd_pkg::C_LD_IMM, pcd_pkg::C_LD_DIR,
      pcd_pkg::C_ST_DIR, pcd_pkg::C_LD_BNK, pcd_pkg::C_MV_DIMM, pcd_pkg::C_LD_PTR}
    |-> cnt_reg == {2'b00, dec.len};
  endproperty
  a_len_time: assert property (p_len_time)
    else $error("clock count differs from instruction length");

  property p_cond_time;
    @(posedge sys_clk) disable iff (!resetn)
    commit && dec.cond |-> cnt_reg == {2'b00, dec.len} + {3'b000, taken};
  endproperty
  a_cond_time: assert property (p_cond_time)
    else $error("conditional branch clock count wrong");

  property p_rel_tgt;
    @(posedge sys_clk) disable iff (!resetn)
    commit && dec.cls == pcd_pkg::C_SJMP |=> pc_reg == $past(pc_reg) + 16'h0002 + $past(rel_ext);
  endproperty
  a_rel_tgt: assert property (p_rel_tgt)
    else $error("short jump target wrong");

  property p_page_tgt;
    @(posedge sys_clk) disable iff (!resetn)
    commit && dec.cls inside {pcd_pkg::C_AJMP, pcd_pkg::C_ACALL}
    |=> pc_reg[15:11] == $past(seq_page) && pc_reg[7:0] == $past(b1);
  endproperty
  a_page_tgt: assert property (p_page_tgt)
    else $error("page-local target left its page");

  property p_full_tgt;
    @(posedge sys_clk) disable iff (!resetn)
    commit && dec.cls inside {pcd_pkg::C_LJMP, pcd_pkg::C_LCALL}
    |=> pc_reg == {$past(b1), $past(b2)};
  endproperty
  a_full_tgt: assert property (p_full_tgt)
    else $error("long target not loaded");

  property p_nop2;
    @(posedge sys_clk) disable iff (!resetn)
    commit && op == pcd_pkg::OP_NOP2
    |=> pc_reg == $past(pc_reg) + 16'h0001 && $stable(work_reg) && $stable(stk_reg);
  endproperty
  a_nop2: assert property (p_nop2)
    else $error("spare opcode changed state");

  property p_stk_rst;
    @(posedge sys_clk) $rose(resetn) |-> stk_reg == pcd_pkg::STK_RST;
  endproperty
  a_stk_rst: assert property (p_stk_rst)
    else $error("stack index not 0x07 after reset");

  property p_push;
    @(posedge sys_clk) disable iff (!resetn)
    commit && dec.cls == pcd_pkg::C_PUSH && b1 != pcd_pkg::A_STK
    |=> stk_reg == $past(stk_reg) + 8'h01 && ram_mem[stk_reg] == $past(push_val);
  endproperty
  a_push: assert property (p_push)
    else $error("push did not store above the index");
endmodule : pcd_core

// [design/pcd_decode.sv]
// Purpose: Opcode decode into class, length and base cycle count
// Assumes: Opcode byte valid in the same cycle
// Notes:   Length covers every opcode, so unexecuted ones still step right
module pcd_decode (
  // Opcode
  input  wire logic [7:0]   opcode,
  // Decoded instruction
  output pcd_pkg::pcd_dec_t dec
);
  function automatic logic [1:0] len_of(input logic [7:0] op);
    casez (op)
      8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63, 8'h75, 8'h85,
      8'h90, 8'hd5, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'b1011_1???: return 2'd3;
      8'h?1, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h42, 8'h52, 8'h62, 8'h72,
      8'h82, 8'h92, 8'ha0, 8'ha2, 8'hb0, 8'hb2, 8'hc2, 8'hd2, 8'hc0, 8'hd0,
      8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94, 8'h76, 8'h77, 8'h86,
      8'h87, 8'ha6, 8'ha7, 8'b0111_1???, 8'b1000_1???, 8'b1010_1???,
      8'b1101_1???: return 2'd2;
      8'h?5: return (op == pcd_pkg::OP_NOP2) ? 2'd1 : 2'd2;
      default: return 2'd1;
    endcase
  endfunction : len_of

  function automatic logic [3:0] cyc_of(input logic [7:0] op, input logic [1:0] ln);
    casez (op)
      8'h02, 8'h12, 8'ha4: return 4'h4;
      8'h?1, 8'h80, 8'h73, 8'h83, 8'h93, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2,
      8'hf3: return 4'h3;
      8'h22, 8'h32: return 4'h5;
      8'h84: return pcd_pkg::MAX_CYC;
      default: return {2'b00, ln};
    endcase
  endfunction : cyc_of

  function automatic logic cond_of(input logic [7:0] op);
    casez (op)
      8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'hb4, 8'hb5, 8'hb6,
      8'hb7, 8'b1011_1???, 8'hd5, 8'b1101_1???: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : cond_of

  function automatic pcd_pkg::pcd_cls_t cls_of(input logic [7:0] op);
    casez (op)
      pcd_pkg::OP_NOP, pcd_pkg::OP_NOP2: return pcd_pkg::C_NOP;
      8'h?1: return op[4] ? pcd_pkg::C_ACALL : pcd_pkg::C_AJMP;
      8'h02: return pcd_pkg::C_LJMP;
      8'h12: return pcd_pkg::C_LCALL;
      8'h80: return pcd_pkg::C_SJMP;
      8'h40: return pcd_pkg::C_JC;
      8'h50: return pcd_pkg::C_JNC;
      8'h60: return pcd_pkg::C_JZ;
      8'h70: return pcd_pkg::C_JNZ;
      8'h22: return pcd_pkg::C_RET;
      8'hc0: return pcd_pkg::C_PUSH;
      8'hd0: return pcd_pkg::C_POP;
      8'h74: return pcd_pkg::C_LD_IMM;
      8'he5: return pcd_pkg::C_LD_DIR;
      8'hf5: return pcd_pkg::C_ST_DIR;
      8'b1110_1???: return pcd_pkg::C_LD_BNK;
      8'b1111_1???: return pcd_pkg::C_ST_BNK;
      8'he6, 8'he7: return pcd_pkg::C_LD_IND;
      8'hf6, 8'hf7: return pcd_pkg::C_ST_IND;
      8'h75: return pcd_pkg::C_MV_DIMM;
      8'h90: return pcd_pkg::C_LD_PTR;
      8'h04: return pcd_pkg::C_INC_W;
      8'h24: return pcd_pkg::C_ADD_IMM;
      8'hc2: return pcd_pkg::C_CLR_BIT;
      8'hd2: return pcd_pkg::C_SET_BIT;
      default: return pcd_pkg::C_OTHER;
    endcase
  endfunction : cls_of

  assign dec.cls  = cls_of(opcode);
  assign dec.len  = len_of(opcode);
  assign dec.cyc  = cyc_of(opcode, len_of(opcode));
  assign dec.cond = cond_of(opcode);
endmodule : pcd_decode

// [design/pcd_operand.sv]
// Purpose: Operand addresses and branch targets
// Assumes: pc_seq is the address of the following instruction
// Notes:   Pure combinational
module pcd_operand (
  // Instruction bytes
  input  wire logic [7:0]  op,
  input  wire logic [7:0]  b1,
  input  wire logic [7:0]  b2,
  // Context
  input  wire logic [1:0]  bank,
  input  wire logic [15:0] pc_seq,
  // Results
  output logic [7:0]       bank_addr,
  output logic [7:0]       ptr_addr,
  output logic [7:0]       bit_byte,
  output logic [15:0]      rel_tgt,
  output logic [15:0]      page_tgt,
  output logic [15:0]      full_tgt
);
  assign bank_addr = {3'b000, bank, op[2:0]};
  assign ptr_addr  = {3'b000, bank, 2'b00, op[0]};
  assign bit_byte  = b1[7] ? {b1[7:3], 3'b000} : pcd_pkg::BIT_BASE + {4'h0, b1[6:3]};
  assign rel_tgt   = pc_seq + {{8{b1[7]}}, b1};
  assign page_tgt  = {pc_seq[15:11], op[7:5], b1};
  assign full_tgt  = {b1, b2};
endmodule : pcd_operand

// [design/pcd_pkg.sv]
// Purpose: Shared constants and types of the multi-cycle 8051-style core
// Assumes: One 20 MHz sys_clk, synchronous active-low reset
// Notes:   Register constants are direct-space byte addresses
package pcd_pkg;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] A_STK    = 8'h81;
  localparam logic [7:0] A_PTRL   = 8'h82;
  localparam logic [7:0] A_PTRH   = 8'h83;
  localparam logic [7:0] A_STAT   = 8'hd0;
  localparam logic [7:0] A_WORK   = 8'he0;
  localparam logic [7:0] A_SECOND = 8'hf0;
  localparam logic [7:0] STK_RST  = 8'h07;
  localparam logic [7:0] REG_RST  = 8'h00;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam logic [7:0] OP_NOP   = 8'h00;
  localparam logic [7:0] OP_NOP2  = 8'ha5;
  localparam int         F_CY     = 7;
  localparam int         F_AC     = 6;
  localparam int         F_BNKH   = 4;
  localparam int         F_BNKL   = 3;
  localparam int         F_OV     = 2;
  localparam logic [3:0] MAX_CYC  = 4'h8;
  localparam int         NUM_BP   = 4;

  typedef enum logic [4:0] {
    C_NOP, C_AJMP, C_ACALL, C_LJMP, C_LCALL, C_SJMP, C_JC, C_JNC, C_JZ,
    C_JNZ, C_RET, C_PUSH, C_POP, C_LD_IMM, C_LD_DIR, C_ST_DIR, C_LD_BNK,
    C_ST_BNK, C_LD_IND, C_ST_IND, C_MV_DIMM, C_LD_PTR, C_INC_W, C_ADD_IMM,
    C_CLR_BIT, C_SET_BIT, C_OTHER
  } pcd_cls_t;

  typedef struct packed {
    pcd_cls_t   cls;
    logic [1:0] len;
    logic [3:0] cyc;
    logic       cond;
  } pcd_dec_t;

  typedef enum logic [1:0] {ST_EXEC = 2'b01, ST_HALT = 2'b10} pcd_state_t;

  typedef struct packed {
    logic       halt;
    logic       run;
    logic       step;
    logic       we;
    logic       sfr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcd_dbg_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } pcd_sfr_wr_t;
endpackage : pcd_pkg

// [verif/pcd_code_rom.sv]
// Purpose: Program memory model holding a fixed test program
// Assumes: Asynchronous read, three bytes from code_addr upward
// Notes:   Unloaded locations read as the no-operation opcode
module pcd_code_rom (
  // Fetch address
  input  wire logic [15:0] code_addr,
  // Fetched bytes
  output logic [23:0]      code_bytes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  logic [7:0] img [0:40];
  logic [7:0] sub [0:8];
  logic [7:0] a;
  initial begin
    img = '{8'h00, 8'ha5, 8'h74, 8'h55, 8'hf5, 8'h90, 8'h02, 8'h00, 8'h10, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'h05, 8'h70, 8'h02,
            8'h00, 8'h00, 8'h01, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'hc0, 8'he0, 8'hf5, 8'h30, 8'h12, 8'h00, 8'h40, 8'h80,
            8'hfe};
    // Subroutine at 0x40: bit sets, bank 2 stores, add with flags, return
    sub = '{8'hd2, 8'he1, 8'hd2, 8'hd4, 8'hf8, 8'hf6, 8'h24, 8'ha9, 8'h22};
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (img[i]) mem[i] = img[i];
    foreach (sub[i]) mem[i + 8'h40] = sub[i];
  end
  assign a = code_addr[7:0];
  assign code_bytes = {mem[8'(a + 8'h02)], mem[8'(a + 8'h01)], mem[a]};
endmodule : pcd_code_rom

// [verif/tb.sv]
// Purpose: Self-checking bench for the core: fetch timing, writes, debug access
// Assumes: Inputs driven on the falling edge
// Notes:   Fetch trace checked once per cycle against a cycle table
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 sys_clk;
  logic                 resetn;
  logic [15:0]          code_addr;
  logic [23:0]          code_bytes;
  pcd_pkg::pcd_sfr_wr_t sfr_wr;
  pcd_pkg::pcd_dbg_t    dbg_req;
  logic [3:0]           dbg_bp_en;
  logic [3:0][15:0]     dbg_bp_addr;
  logic                 dbg_halted;
  logic [7:0]           dbg_rdata;
  int                   bad_count;
  int                   n_tests;
  int                   cyc_cnt;
  int                   wr_n;
  logic [7:0]           wr_a;
  logic [7:0]           wr_d;
  logic [15:0]          t_addr [0:17];
  int                   t_cyc  [0:17];

  pcd_core pcd_core_inst (.sys_clk(sys_clk), .resetn(resetn), .code_addr(code_addr),
    .code_bytes(code_bytes), .sfr_wr(sfr_wr), .dbg_req(dbg_req), .dbg_bp_en(dbg_bp_en),
    .dbg_bp_addr(dbg_bp_addr), .dbg_halted(dbg_halted), .dbg_rdata(dbg_rdata));
  pcd_code_rom pcd_code_rom_inst (.code_addr(code_addr), .code_bytes(code_bytes));

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  task automatic complete_run();
    $display("Checks made %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic dbg_read(logic sfr, logic [7:0] addr, logic [7:0] exp, string name);
    dbg_req.sfr  = sfr;
    dbg_req.addr = addr;
    @(negedge sys_clk);
    chk(name, {8'h00, exp}, {8'h00, dbg_rdata});
  endtask : dbg_read

  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 2000) begin
      bad_count++;
      complete_run();
    end
  end

  // Capture peripheral write pulses
  always @(negedge sys_clk) begin
    if (sfr_wr.we === 1'b1) begin
      wr_n++;
      wr_a = sfr_wr.addr;
      wr_d = sfr_wr.data;
    end
  end

  initial begin
    bad_count   = 0;
    n_tests     = 0;
    cyc_cnt     = 0;
    wr_n        = 0;
    resetn      = 1'b0;
    dbg_req     = '0;
    dbg_bp_en   = '0;
    dbg_bp_addr = '0;
    t_addr = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0006, 16'h0010, 16'h0012,
               16'h0016, 16'h0020, 16'h0022, 16'h0024, 16'h0040, 16'h0042, 16'h0044,
               16'h0045, 16'h0046, 16'h0048, 16'h0027};
    t_cyc  = '{1, 1, 2, 2, 4, 2, 3, 3, 2, 2, 4, 2, 2, 1, 1, 2, 5, 3};
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    // NOP, 0xA5, MOV A#, MOV dir, LJMP, JZ no, JNZ yes, AJMP, PUSH, MOV dir, LCALL,
    // SETB, SETB, MOV R0, MOV @R0, ADD, RET, SJMP
    for (int i = 0; i < 18; i++) begin
      for (int k = 0; k < t_cyc[i]; k++) begin
        chk("code_addr", t_addr[i], code_addr);
        @(negedge sys_clk);
      end
    end
    chk("loop addr", 16'h0027, code_addr);
    chk("write count", 16'd1, 16'(wr_n));
    chk("write addr", 16'h0090, {8'h00, wr_a});
    chk("write data", 16'h0055, {8'h00, wr_d});
    $display("Test fetch trace done");
    dbg_req.halt = 1'b1;
    @(negedge sys_clk);
    dbg_req.halt = 1'b0;
    for (int w = 0; w < 20 && dbg_halted !== 1'b1; w++) @(negedge sys_clk);
    chk("halted", 16'h0001, {15'h0, dbg_halted});
    dbg_read(1'b1, pcd_pkg::A_STK, 8'h08, "stack index");
    dbg_read(1'b0, 8'h08, 8'h55, "stack byte");
    dbg_read(1'b0, 8'h30, 8'h55, "ram 0x30");
    dbg_read(1'b1, pcd_pkg::A_WORK, 8'h00, "work reg");
    dbg_read(1'b1, pcd_pkg::A_STAT, 8'hd0, "status word");
    dbg_read(1'b0, 8'h10, 8'h57, "bank 2 reg 0");
    dbg_read(1'b0, 8'h57, 8'h57, "indirect byte");
    dbg_read(1'b0, 8'h09, 8'h27, "call return low");
    // All eight bits written, read back unchanged
    dbg_req.we    = 1'b1;
    dbg_req.sfr   = 1'b1;
    dbg_req.addr  = pcd_pkg::A_SECOND;
    dbg_req.wdata = 8'h3c;
    @(negedge sys_clk);
    dbg_req.we = 1'b0;
    dbg_read(1'b1, pcd_pkg::A_SECOND, 8'h3c, "second reg");
    dbg_req.step = 1'b1;
    @(negedge sys_clk);
    dbg_req.step = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("step halted", 16'h0001, {15'h0, dbg_halted});
    chk("step addr", 16'h0027, code_addr);
    dbg_req.run = 1'b1;
    @(negedge sys_clk);
    dbg_req.run = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("run halted", 16'h0000, {15'h0, dbg_halted});
    dbg_bp_addr[1] = 16'h0027;
    dbg_bp_en      = 4'b0010;
    repeat (10) @(negedge sys_clk);
    chk("bp halted", 16'h0001, {15'h0, dbg_halted});
    chk("bp addr", 16'h0027, code_addr);
    $display("Test debug access done");
    complete_run();
  end
endmodule : tb
